// >>> core/opp_host.sv
// file: host controller that reads, programs, verifies and inhibits a 4096 x 8 otp prom
`timescale 1ns/1ps
`default_nettype none
// How it works
// - we select with chip select and gate the read with output gate.
// - program: gate at 21 V, data and address driven by us.
// - one low select pulse, 10 ms by default; nothing keeps a set count within 9 to 11 ms.
// - one pulse per programmed location, any address order.
// - verify programmed byte afterwards by reading back.
// - verify holds gate and select low; prom drives stored word.
// - parallel devices share lines; same sequence programs them together.
module opp_host #(
  parameter int unsigned PULSE_CYCLES = opp_pkg::PULSE_CYC
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic req_valid_i,
  input wire opp_pkg::opp_req_s req_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [opp_pkg::DATA_W-1:0] rsp_data_o,
  output logic rsp_mismatch_o,
  output logic chip_sel_n_o,
  output logic gate_n_o,
  output logic vpp_hi_o,
  output logic [opp_pkg::ADDR_W-1:0] addr_pins_o,
  input wire logic [opp_pkg::DATA_W-1:0] data_pins_i,
  output logic [opp_pkg::DATA_W-1:0] data_pins_o,
  output logic data_pins_oe_n_o
);
  typedef enum logic [2:0] {
    OPP_IDLE = 3'b000,
    OPP_SETUP = 3'b001,
    OPP_PULSE = 3'b010,
    OPP_HOLD = 3'b011,
    OPP_ACCESS = 3'b100,
    OPP_DONE = 3'b101
  } opp_state_e;

  opp_state_e state_reg;
  opp_pkg::opp_req_s cur_reg;
  logic [opp_pkg::DATA_W-1:0] sync1_reg;
  logic [opp_pkg::DATA_W-1:0] sync2_reg;
  logic tmr_load;
  logic [opp_pkg::CNT_W-1:0] tmr_count;
  logic tmr_done;
  logic verify_after_reg;
  logic hold_end;
  logic access_end;

  // a zero count is lifted to one cycle; keeping it inside 9 to 11 ms is up to whoever sets it
  localparam int unsigned PULSE_USE = (PULSE_CYCLES < 1) ? 1 : PULSE_CYCLES;
  // read window also covers the two synchroniser stages, so the byte taken has had its full access time
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned ACCESS_WAIT = opp_pkg::ACCESS_CYC + SYNC_STAGES;

  // program and inhibit share one high-voltage timeline; the select pulse differs and only program adds a read-back
  function automatic logic hv_timeline(input opp_pkg::opp_op_e kind);
    return (kind == opp_pkg::OPP_OP_PROG) || (kind == opp_pkg::OPP_OP_INHIBIT);
  endfunction : hv_timeline

  assign hold_end = (state_reg == OPP_HOLD) && tmr_done;
  assign access_end = (state_reg == OPP_ACCESS) && tmr_done;

  // data pins come from another chip: two flops before any use
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= data_pins_i;
      sync2_reg <= sync1_reg;
    end
  end

  opp_timer u_timer (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .load_i(tmr_load),
    .count_i(tmr_count),
    .done_o(tmr_done)
  );

  // timer load strobe and count, picked from the state being entered
  always_comb begin
    tmr_load = 1'b0;
    tmr_count = '0;
    case (state_reg)
      OPP_IDLE: begin
        if (req_valid_i) begin
          tmr_load = 1'b1;
          if (hv_timeline(req_i.op)) begin
            tmr_count = opp_pkg::CNT_W'(opp_pkg::SETUP_CYC);
          end else begin
            tmr_count = opp_pkg::CNT_W'(ACCESS_WAIT);
          end
        end
      end
      OPP_SETUP: begin
        tmr_load = tmr_done;
        tmr_count = opp_pkg::CNT_W'(PULSE_USE);
      end
      OPP_PULSE: begin
        tmr_load = tmr_done;
        tmr_count = opp_pkg::CNT_W'(opp_pkg::HOLD_CYC);
      end
      OPP_HOLD: begin
        tmr_load = hold_end && verify_after_reg;
        tmr_count = opp_pkg::CNT_W'(ACCESS_WAIT);
      end
      default: begin
        tmr_load = 1'b0;
        tmr_count = '0;
      end
    endcase
  end

  // sequencer
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= OPP_IDLE;
      cur_reg <= '0;
      verify_after_reg <= 1'b0;
    end else begin
      case (state_reg)
        OPP_IDLE: begin
          if (req_valid_i) begin
            // only sampled while idle: a request raised while busy is taken on return to idle if req_valid_i is still high, not queued
            cur_reg <= req_i;
            // a program is always followed by a read-back of the same byte
            verify_after_reg <= (req_i.op == opp_pkg::OPP_OP_PROG);
            if (hv_timeline(req_i.op)) begin
              state_reg <= OPP_SETUP;
            end else begin
              state_reg <= OPP_ACCESS;
            end
          end
        end
        OPP_SETUP: if (tmr_done) state_reg <= OPP_PULSE;
        OPP_PULSE: if (tmr_done) state_reg <= OPP_HOLD;
        OPP_HOLD: begin
          if (tmr_done) begin
            state_reg <= verify_after_reg ? OPP_ACCESS : OPP_DONE;
          end
        end
        OPP_ACCESS: if (tmr_done) state_reg <= OPP_DONE;
        OPP_DONE: state_reg <= OPP_IDLE;
        default: state_reg <= OPP_IDLE;
      endcase
    end
  end

  // pin drive: all registered
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      chip_sel_n_o <= 1'b1;
      gate_n_o <= 1'b1;
      vpp_hi_o <= 1'b0;
      addr_pins_o <= '0;
      data_pins_o <= '0;
      data_pins_oe_n_o <= 1'b1;
    end else begin
      addr_pins_o <= cur_reg.addr;
      data_pins_o <= cur_reg.data;
      case (state_reg)
        OPP_SETUP, OPP_HOLD: begin
          chip_sel_n_o <= 1'b1;
          gate_n_o <= 1'b1;
          vpp_hi_o <= ~(hold_end && verify_after_reg);
          // data goes out with the address so it has settled long before the select pulse
          // and is handed back one cycle before the gate falls for the read-back
          data_pins_oe_n_o <= hold_end;
        end
        OPP_PULSE: begin
          // inhibit keeps select high through the pulse window
          chip_sel_n_o <= (cur_reg.op == opp_pkg::OPP_OP_INHIBIT) || tmr_done;
          gate_n_o <= 1'b1;
          vpp_hi_o <= 1'b1;
          data_pins_oe_n_o <= 1'b0;
        end
        OPP_ACCESS: begin
          // select and gate low together for read and verify; bus released first
          chip_sel_n_o <= tmr_done;
          gate_n_o <= tmr_done;
          vpp_hi_o <= 1'b0;
          data_pins_oe_n_o <= 1'b1;
        end
        default: begin
          // standby: select high, gate high at logic level
          chip_sel_n_o <= 1'b1;
          gate_n_o <= 1'b1;
          vpp_hi_o <= 1'b0;
          data_pins_oe_n_o <= 1'b1;
        end
      endcase
    end
  end

  // answer: data captured at the end of the access window
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      req_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_data_o <= '0;
      rsp_mismatch_o <= 1'b0;
    end else begin
      req_ready_o <= (state_reg == OPP_DONE);
      rsp_valid_o <= (state_reg == OPP_DONE);
      if (access_end) begin
        rsp_data_o <= sync2_reg;
        rsp_mismatch_o <= verify_after_reg && (sync2_reg != cur_reg.data);
      end else if (state_reg == OPP_IDLE && req_valid_i) begin
        rsp_mismatch_o <= 1'b0;
      end
    end
  end
endmodule : opp_host
`default_nettype wire

// >>> core/opp_pkg.sv
// package: constants and carrier types for the otp prom programmer/reader
package opp_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int CLK_HZ = 40_000_000;
  // programming pulse figures in microseconds (nominal, least, longest)
  localparam int PULSE_NOM_US = 10_000;
  localparam int PULSE_MIN_US = 9_000;
  localparam int PULSE_MAX_US = 11_000;
  localparam int SETUP_US = 2;
  localparam int HOLD_US = 2;
  localparam int ACCESS_NS = 450;
  localparam int PULSE_CYC = PULSE_NOM_US * (CLK_HZ / 1_000_000);
  localparam int PULSE_MIN_CYC = (PULSE_MIN_US * (CLK_HZ / 1_000_000));
  localparam int PULSE_MAX_CYC = (PULSE_MAX_US * (CLK_HZ / 1_000_000));
  localparam int SETUP_CYC = SETUP_US * (CLK_HZ / 1_000_000);
  localparam int HOLD_CYC = HOLD_US * (CLK_HZ / 1_000_000);
  localparam int ACCESS_CYC = (ACCESS_NS * (CLK_HZ / 1_000_000) + 999) / 1000 + 1;
  localparam int CNT_W = 20;

  typedef enum logic [1:0] {
    OPP_OP_READ = 2'b00,
    OPP_OP_PROG = 2'b01,
    OPP_OP_VERIFY = 2'b10,
    OPP_OP_INHIBIT = 2'b11
  } opp_op_e;

  typedef struct packed {
    opp_op_e op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } opp_req_s;

  // pin-side group driven towards the prom
  typedef struct packed {
    logic chip_sel_n;
    logic gate_n;
    logic vpp_hi;
    logic [ADDR_W-1:0] addr_pins;
  } opp_pins_s;
endpackage : opp_pkg

// >>> core/opp_timer.sv
// file: down-counting phase timer with a done pulse
`timescale 1ns/1ps
`default_nettype none
module opp_timer (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic load_i,
  input wire logic [opp_pkg::CNT_W-1:0] count_i,
  output logic done_o
);
  logic [opp_pkg::CNT_W-1:0] cnt_reg;
  logic run_reg;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (load_i) begin
        cnt_reg <= count_i;
        run_reg <= 1'b1;
      end else if (run_reg) begin
        if (cnt_reg <= opp_pkg::CNT_W'(1)) begin
          run_reg <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - opp_pkg::CNT_W'(1);
        end
      end
    end
  end
endmodule : opp_timer
`default_nettype wire

// >>> tb/opp_prom_model.sv
// behavioural otp prom seen by the host
`timescale 1ns/1ps
`default_nettype none
module opp_prom_model (
  input wire logic clk_sys_i,
  input wire logic chip_sel_n_i,
  input wire logic gate_n_i,
  input wire logic vpp_hi_i,
  input wire logic [opp_pkg::ADDR_W-1:0] addr_pins_i,
  input wire logic [7:0] data_pins_i,
  output logic [7:0] data_pins_o
);
  logic [7:0] mem [4096];
  logic [7:0] junk = 8'h5a;
  initial for (int i = 0; i < 4096; i++) mem[i] = 8'hff;
  // a released bus toggles, so a stale byte never passes for read data
  assign data_pins_o = (!chip_sel_n_i && !gate_n_i && !vpp_hi_i) ? mem[addr_pins_i] : junk;
  always @(posedge clk_sys_i) junk <= ~junk;
  // one-time cells: bits only clear, at the end of a select pulse under high voltage
  always @(posedge chip_sel_n_i) if (vpp_hi_i) mem[addr_pins_i] &= data_pins_i;
endmodule : opp_prom_model
`default_nettype wire

// >>> tb/opp_host_asserts.sv
// pin assertions for the otp prom host
`timescale 1ns/1ps
`default_nettype none
module opp_host_asserts #(
  parameter int unsigned PULSE_CYCLES = opp_pkg::PULSE_CYC
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic req_ready_o,
  input wire logic rsp_valid_o,
  input wire logic chip_sel_n_o,
  input wire logic gate_n_o,
  input wire logic vpp_hi_o,
  input wire logic [opp_pkg::ADDR_W-1:0] addr_pins_o,
  input wire logic data_pins_oe_n_o
);
  int unsigned low_cnt;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  always_ff @(posedge clk_sys_i or posedge reset_i)
    if (reset_i) low_cnt <= 0;
    else low_cnt <= (!chip_sel_n_o && vpp_hi_o) ? low_cnt + 1 : 0;
  a_pulse_width: assert property ($rose(chip_sel_n_o) && vpp_hi_o |-> low_cnt == PULSE_CYCLES)
    else $error("select pulse width off");
  a_read_no_drive: assert property (!gate_n_o |-> data_pins_oe_n_o && !vpp_hi_o)
    else $error("host drives data during read");
  a_vpp_gate_high: assert property (vpp_hi_o |-> gate_n_o)
    else $error("gate low under high voltage");
  a_pulse_data: assert property (!chip_sel_n_o && vpp_hi_o |-> !data_pins_oe_n_o)
    else $error("data not driven in pulse");
  a_read_select: assert property (!gate_n_o |-> !chip_sel_n_o)
    else $error("gate without select");
  a_addr_held: assert property (vpp_hi_o && $past(vpp_hi_o) |-> $stable(addr_pins_o))
    else $error("address moved while programming");
  a_hold_end: assert property ($fell(vpp_hi_o) |-> chip_sel_n_o && $past(chip_sel_n_o, 8))
    else $error("high voltage dropped inside pulse");
  a_rsp_ready: assert property (rsp_valid_o |-> req_ready_o ##1 !rsp_valid_o)
    else $error("response pulse malformed");
  a_read_answer: assert property ($fell(gate_n_o) |-> ##[1:40] rsp_valid_o)
    else $error("read not answered");
  cover property ($rose(chip_sel_n_o) && vpp_hi_o);
  cover property ($fell(gate_n_o));
  cover property (rsp_valid_o && !vpp_hi_o);
endmodule : opp_host_asserts
bind opp_host opp_host_asserts #(.PULSE_CYCLES(PULSE_CYCLES)) opp_host_asserts_inst (.clk_sys_i(clk_sys_i),
  .reset_i(reset_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .chip_sel_n_o(chip_sel_n_o),
  .gate_n_o(gate_n_o), .vpp_hi_o(vpp_hi_o), .addr_pins_o(addr_pins_o), .data_pins_oe_n_o(data_pins_oe_n_o));
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for the otp prom host
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int unsigned PULSE = 50;
  logic clk_sys_i = 0, reset_i = 1, req_valid_i = 0;
  opp_pkg::opp_req_s req_i = '0;
  logic req_ready_o, rsp_valid_o, rsp_mismatch_o, chip_sel_n_o, gate_n_o, vpp_hi_o, data_pins_oe_n_o;
  logic [7:0] rsp_data_o, data_pins_o, prom_q, bus;
  logic [11:0] addr_pins_o;
  int err_total = 0, n_tests = 0, sel_cyc = 0, n;
  always #12.5 clk_sys_i = ~clk_sys_i;
  assign bus = data_pins_oe_n_o ? prom_q : data_pins_o;
  always @(posedge clk_sys_i) if (!chip_sel_n_o && vpp_hi_o) sel_cyc++;
  opp_host #(.PULSE_CYCLES(PULSE)) opp_host_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o), .rsp_mismatch_o(rsp_mismatch_o), .chip_sel_n_o(chip_sel_n_o), .gate_n_o(gate_n_o),
    .vpp_hi_o(vpp_hi_o), .addr_pins_o(addr_pins_o), .data_pins_i(bus), .data_pins_o(data_pins_o),
    .data_pins_oe_n_o(data_pins_oe_n_o));
  opp_prom_model opp_prom_model_inst (.clk_sys_i(clk_sys_i), .chip_sel_n_i(chip_sel_n_o), .gate_n_i(gate_n_o),
    .vpp_hi_i(vpp_hi_o), .addr_pins_i(addr_pins_o), .data_pins_i(bus), .data_pins_o(prom_q));
  task automatic conclude();
    if (err_total == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic op(input opp_pkg::opp_op_e k, input logic [11:0] a, input logic [7:0] d);
    int i;
    @(negedge clk_sys_i);
    req_i = '{k, a, d};
    req_valid_i = 1;
    for (i = 0; i < 2000 && rsp_valid_o !== 1'b1; i++) @(negedge clk_sys_i);
    req_valid_i = 0;
    if (i == 2000) begin
      chk(8'h00, 8'h01);
      conclude();
    end else begin
      chk({7'h0, req_ready_o}, 8'h01);
    end
  endtask : op
  task automatic s_blank();
    chk({4'h0, chip_sel_n_o, gate_n_o, vpp_hi_o, data_pins_oe_n_o}, 8'h0d);
    op(opp_pkg::OPP_OP_READ, 12'hfff, 8'h00);
    chk(rsp_data_o, 8'hff);
  endtask : s_blank
  task automatic s_prog();
    n = sel_cyc;
    op(opp_pkg::OPP_OP_PROG, 12'h0a5, 8'h3c);
    chk(8'(sel_cyc - n), 8'(PULSE));
    chk({rsp_mismatch_o, rsp_data_o[6:0]}, 8'h3c);
    op(opp_pkg::OPP_OP_VERIFY, 12'h0a5, 8'h00);
    chk(rsp_data_o, 8'h3c);
  endtask : s_prog
  task automatic s_reprog();
    op(opp_pkg::OPP_OP_PROG, 12'h000, 8'h81);
    chk(rsp_data_o, 8'h81);
    op(opp_pkg::OPP_OP_PROG, 12'h0a5, 8'hc3);
    chk({rsp_mismatch_o, rsp_data_o[6:0]}, 8'h80);
    op(opp_pkg::OPP_OP_READ, 12'h000, 8'h00);
    chk({rsp_mismatch_o, rsp_data_o[6:0]}, 8'h01);
  endtask : s_reprog
  task automatic s_inhibit();
    n = sel_cyc;
    op(opp_pkg::OPP_OP_INHIBIT, 12'h123, 8'h00);
    chk(8'(sel_cyc - n), 8'h00);
    op(opp_pkg::OPP_OP_READ, 12'h123, 8'h00);
    chk(rsp_data_o, 8'hff);
  endtask : s_inhibit
  initial begin
    repeat (2) @(negedge clk_sys_i);
    reset_i = 0;
    s_blank();
    s_prog();
    s_reprog();
    s_inhibit();
    conclude();
  end
endmodule : tb
`default_nettype wire
